// [hw/frame_decoder_cfg.svh]
// Purpose: address map, region codes and protection flags of the peripheral frame decoder
// Assumes: word (16-bit) addresses of 22 bits from the cpu memory bus
// Notes:   region bounds are inclusive word addresses
//
// Contract
// - three separately decoded peripheral register frames
// - frame zero sits directly on memory bus
// - frame one uses 32-bit peripheral bus
// - frame two uses 16-bit peripheral bus
// - frame zero accepts 16 and 32-bit accesses
// - protected writes blocked until unlock instruction
// - lock instruction blocks protected writes again
// - flash needs unlock and code security grant
// - frame two ignores 32-bit accesses
// - can control registers: aligned 32-bit only
// - some can control protected; mailbox never
// - code security block is sixteen words
`ifndef FRAME_DECODER_CFG_SVH
`define FRAME_DECODER_CFG_SVH

`define ADDR_W            22
`define REGION_COUNT      23
// frame zero regions
`define EMU_LO            22'h00_0880
`define EMU_HI            22'h00_09FF
`define FLASH_LO          22'h00_0A80
`define FLASH_HI          22'h00_0ADF
`define CODESEC_LO        22'h00_0AE0
`define CODESEC_HI        22'h00_0AEF
`define EXTBUS_LO         22'h00_0B20
`define EXTBUS_HI         22'h00_0B3F
`define TIMER_LO          22'h00_0C00
`define TIMER_HI          22'h00_0C3F
`define INTEXP_LO         22'h00_0CE0
`define INTEXP_HI         22'h00_0CFF
`define VECTOR_LO         22'h00_0D00
`define VECTOR_HI         22'h00_0DFF
// frame one regions
`define CANCTL_LO         22'h00_6000
`define CANCTL_HI         22'h00_60FF
`define CANMBX_LO         22'h00_6100
`define CANMBX_HI         22'h00_61FF
// frame two regions
`define SYSCTL_LO         22'h00_7010
`define SYSCTL_HI         22'h00_702F
`define SPIA_LO           22'h00_7040
`define SPIA_HI           22'h00_704F
`define SCIA_LO           22'h00_7050
`define SCIA_HI           22'h00_705F
`define EXTINT_LO         22'h00_7070
`define EXTINT_HI         22'h00_707F
`define PINMUX_LO         22'h00_70C0
`define PINMUX_HI         22'h00_70DF
`define PINDAT_LO         22'h00_70E0
`define PINDAT_HI         22'h00_70FF
`define CONV_LO           22'h00_7100
`define CONV_HI           22'h00_711F
`define EVA_LO            22'h00_7400
`define EVA_HI            22'h00_743F
`define EVB_LO            22'h00_7500
`define EVB_HI            22'h00_753F
`define SCIB_LO           22'h00_7750
`define SCIB_HI           22'h00_775F
`define SERPORT_LO        22'h00_7800
`define SERPORT_HI        22'h00_783F
// unlock state after reset
`define UNLOCK_RESET      1'b0

`endif

// [hw/frame_decoder_pkg.sv]
// Purpose: types shared by the peripheral frame decoder files
// Assumes: constants come from frame_decoder_cfg.svh
// Notes:   none
package frame_decoder_pkg;

    // which frame an access lands in
    typedef enum logic [1:0] {
        FRAME_NONE,
        FRAME_ZERO,
        FRAME_ONE,
        FRAME_TWO
    } frame_t;

    // outcome of one access
    typedef enum logic [1:0] {
        RESULT_ACCEPTED,
        RESULT_PROTECTED,
        RESULT_WIDTH,
        RESULT_RESERVED
    } result_t;

    // cpu request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        wide;      // 32-bit access
        logic [21:0] addr;
        logic [31:0] wdata;
    } cpu_req_t;

    // decoder answer
    typedef struct packed {
        logic        done;
        result_t     result;
        logic [31:0] rdata;
    } cpu_rsp_t;

    // one peripheral bus request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        wide;
        logic [21:0] addr;
        logic [31:0] wdata;
    } per_req_t;

    // combinational region lookup
    typedef struct packed {
        frame_t      frame;
        logic [22:0] hit;       // one-hot region hit
        logic        protect;   // needs unlock
        logic        flash;     // needs code security grant too
        logic        can_ctl;   // aligned 32-bit only
    } region_info_t;

endpackage

// [hw/region_lookup.sv]
// Purpose: maps a word address to frame, one-hot region and protection attributes
// Assumes: purely combinational, same clock domain as the caller
// Notes:   regions never overlap, so at most one hit bit is set
`timescale 1ns/100ps
`include "frame_decoder_cfg.svh"
`default_nettype none
module region_lookup
    import frame_decoder_pkg::*;
(
    input  wire logic [21:0]  addr_in,
    input  wire logic         wide_in,
    output region_info_t      info_out
);

    localparam int N = `REGION_COUNT;
    // region bounds, index order matches hit bits
    localparam logic [N*22-1:0] LO_TAB = {
        `EMU_LO, `FLASH_LO, `CODESEC_LO, `EXTBUS_LO, `TIMER_LO, `INTEXP_LO, `VECTOR_LO,
        `CANCTL_LO, `CANMBX_LO,
        `SYSCTL_LO, `SPIA_LO, `SCIA_LO, `EXTINT_LO, `PINMUX_LO, `PINDAT_LO, `CONV_LO,
        `EVA_LO, `EVB_LO, `SCIB_LO, `SERPORT_LO, 22'h3F_FFFF, 22'h3F_FFFF, 22'h3F_FFFF};
    localparam logic [N*22-1:0] HI_TAB = {
        `EMU_HI, `FLASH_HI, `CODESEC_HI, `EXTBUS_HI, `TIMER_HI, `INTEXP_HI, `VECTOR_HI,
        `CANCTL_HI, `CANMBX_HI,
        `SYSCTL_HI, `SPIA_HI, `SCIA_HI, `EXTINT_HI, `PINMUX_HI, `PINDAT_HI, `CONV_HI,
        `EVA_HI, `EVB_HI, `SCIB_HI, `SERPORT_HI, 22'h00_0000, 22'h00_0000, 22'h00_0000};
    // bit k of table refers to entry N-1-k in the list above
    localparam logic [N-1:0] PROT_TAB = 23'b111_0001_0_0_1000100_0000_000;

    logic [N-1:0] hit;  // raw range hits

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cmp
            assign hit[g] = (addr_in >= LO_TAB[g*22 +: 22]) && (addr_in <= HI_TAB[g*22 +: 22]);
        end
    endgenerate

    // derive frame and attributes from the hit vector
    always_comb begin
        info_out.hit     = hit;
        info_out.protect = |(hit & PROT_TAB);
        info_out.flash   = hit[N-2];
        info_out.can_ctl = hit[N-8];
        if (|hit[N-1 -: 7]) begin
            info_out.frame = FRAME_ZERO;
        end else if (|hit[N-8 -: 2]) begin
            info_out.frame = FRAME_ONE;
        end else if (|hit[N-10 -: 11]) begin
            info_out.frame = FRAME_TWO;
        end else begin
            info_out.frame = FRAME_NONE;
        end
        // wide flag only clears protect on unmapped addresses here; width checks are made by the caller
        if (wide_in && info_out.frame == FRAME_NONE) begin
            info_out.protect = 1'b0;
        end
    end

endmodule
`default_nettype wire

// [hw/peripheral_frame_decoder.sv]
// Purpose: decodes cpu accesses into three peripheral frames with width and write-protection checks
// Assumes: cpu holds a request for one cycle; peripherals answer read data in the same cycle as select
// Notes:   one access per two cycles; request taken when idle
`timescale 1ns/100ps
`include "frame_decoder_cfg.svh"
`default_nettype none
module peripheral_frame_decoder
    import frame_decoder_pkg::*;
(
    input  wire logic         sys_clk_in,        // system clock, 100 MHz
    input  wire logic         reset_n_in,        // async reset, active low
    input  wire cpu_req_t     cpu_req_in,        // cpu access request
    input  wire logic         unlock_exec_in,    // protected_write_unlock executed (pulse)
    input  wire logic         lock_exec_in,      // protected_write_lock executed (pulse)
    input  wire logic         code_sec_grant_in, // code_security_block permits flash access
    input  wire logic [22:0]  can_prot_mask_in,  // unused high bits ignored; bit 0: can control protected subset
    input  wire logic [31:0]  frame0_rdata_in,   // read data from frame zero regions
    input  wire logic [31:0]  frame1_rdata_in,   // read data from 32-bit bus
    input  wire logic [15:0]  frame2_rdata_in,   // read data from 16-bit bus
    output cpu_rsp_t          cpu_rsp_out,       // answer to cpu
    output per_req_t          frame0_req_out,    // direct memory bus request
    output per_req_t          frame1_req_out,    // 32-bit peripheral bus request
    output per_req_t          frame2_req_out,    // 16-bit peripheral bus request
    output logic [22:0]       region_sel_out,    // one-hot region select
    output logic              unlocked_out       // protected writes currently open
);

    // sequencing states
    // two states suffice: every bus answers in one cycle
    typedef enum logic {
        ST_IDLE,
        ST_DATA
    } state_t;

    // all registered state
    // the held answer lives in rsp; f0..f2 are the three buses
    typedef struct packed {
        state_t      state;
        logic        unlocked;
        frame_t      frame;
        cpu_rsp_t    rsp;
        per_req_t    f0;
        per_req_t    f1;
        per_req_t    f2;
        logic [22:0] sel;
    } regs_t;

    // one struct carries every flop of the block, so the reset
    // branch and the register update stay in a single place
    regs_t        cur;       // current state
    regs_t        next_cur;  // next state
    // combinational helpers, valid in the cycle of the request
    region_info_t info;      // decode of incoming address
    result_t      verdict;   // outcome for incoming access
    logic         can_prot;  // incoming access hits protected can control

    // timing of one access, counted in rising edges:
    //   edge 0: request taken, verdict and frame latched
    //   edge 1: bus request and region select drop, read data sampled, answer pulse rises
    //   edge 2: answer pulse drops; a new request may be taken
    // a request offered on edge 1 is dropped without trace,
    // so the cpu spaces its requests at least two cycles apart
    //
    // address lookup; purely combinational, so the verdict is
    // ready in the same cycle as the request
    region_lookup u_lookup (
        .addr_in  (cpu_req_in.addr),
        .wide_in  (cpu_req_in.wide),
        .info_out (info)
    );

    // the mask input stands in for the per-register choice of the
    // can block; only bit zero is used, the other bits are spare,
    // and the mailbox region is never looked at here
    // can control subset protected, mailbox never
    assign can_prot = info.can_ctl && can_prot_mask_in[0];

    // classify the incoming access
    // the checks run in priority order: reserved space first, then
    // bus width, then write protection, then the security grant;
    // the first one that hits decides the outcome
    always_comb begin
        // default: the access goes through
        verdict = RESULT_ACCEPTED;
        if (info.frame == FRAME_NONE) begin
            // no select is raised and a read answers zero
            // reserved, no effect
            verdict = RESULT_RESERVED;
        end else if (info.frame == FRAME_TWO && cpu_req_in.wide) begin
            // the narrow bus would split a wide word into garbage
            // 32-bit ignored in frame two
            verdict = RESULT_WIDTH;
        end else if (info.can_ctl && (!cpu_req_in.wide || cpu_req_in.addr[0])) begin
            // a narrow or odd access would tear a 32-bit register
            // can control aligned 32-bit
            verdict = RESULT_WIDTH;
        end else if (cpu_req_in.write && (info.protect || can_prot) && !cur.unlocked) begin
            // only writes are gated; reads of locked regions go through
            // blocked until unlock
            verdict = RESULT_PROTECTED;
        end else if (cpu_req_in.write && info.flash && !code_sec_grant_in) begin
            verdict = RESULT_PROTECTED;
        end else if (info.flash && !code_sec_grant_in) begin
            // so a secured flash block never leaks its contents
            // flash reads need security grant too
            verdict = RESULT_PROTECTED;
        end
    end

    // next-state logic
    // pulses (answer, bus valids, selects) last one cycle and are
    // cleared by default; frame, result and read data are held so
    // that the cpu may look at them after the answer pulse
    always_comb begin
        next_cur          = cur;
        next_cur.rsp.done = 1'b0;
        next_cur.f0.valid = 1'b0;
        next_cur.f1.valid = 1'b0;
        next_cur.f2.valid = 1'b0;
        next_cur.sel      = '0;
        // the unlock flag changes only on an instruction pulse; an
        // access in the same cycle is judged by the old flag value
        // unlock instruction opens
        if (unlock_exec_in) begin
            next_cur.unlocked = 1'b1;
        end
        // closing wins a tie: a stray unlock cannot leave writes open
        // lock instruction closes, wins over unlock
        if (lock_exec_in) begin
            next_cur.unlocked = 1'b0;
        end
        unique case (cur.state)
            ST_IDLE: begin
                // a request is taken only here; refused accesses still
                // pass through the data state so that every taken
                // request gets exactly one answer
                if (cpu_req_in.valid) begin
                    next_cur.frame = info.frame;
                    next_cur.rsp.result = verdict;
                    next_cur.state = ST_DATA;
                    if (verdict == RESULT_ACCEPTED) begin
                        // regions never overlap, so at most one bit is set
                        // single region select
                        next_cur.sel = info.hit;
                        unique case (info.frame)
                            FRAME_ZERO: begin
                                // frame zero sits on the memory bus itself,
                                // so the request passes unchanged in both widths
                                // both widths pass through
                                next_cur.f0 = '{1'b1, cpu_req_in.write, cpu_req_in.wide,
                                                cpu_req_in.addr, cpu_req_in.wdata};
                            end
                            FRAME_ONE: begin
                                // whole word passes; alignment was checked above for can control only
                                // 32-bit peripheral bus
                                next_cur.f1 = '{1'b1, cpu_req_in.write, cpu_req_in.wide,
                                                cpu_req_in.addr, cpu_req_in.wdata};
                            end
                            FRAME_TWO: begin
                                // upper data half forced to zero, width flag
                                // cleared: the narrow bus has no wide mode
                                // 16-bit peripheral bus
                                next_cur.f2 = '{1'b1, cpu_req_in.write, 1'b0,
                                                cpu_req_in.addr, {16'h0000, cpu_req_in.wdata[15:0]}};
                            end
                            FRAME_NONE: begin
                                // cannot occur for an accepted access
                                next_cur.sel = '0;
                            end
                        endcase
                    end
                end
            end
            ST_DATA: begin
                // answer cpu with data from the selected bus
                // the peripheral drives its read data while its bus
                // request stands, so the word is taken on this edge;
                // refused accesses answer zero and touch no register
                // the answer always rises one edge after the taking edge
                next_cur.state    = ST_IDLE;
                next_cur.rsp.done = 1'b1;
                // zero unless the access was accepted
                next_cur.rsp.rdata = 32'h0000_0000;
                if (cur.rsp.result == RESULT_ACCEPTED) begin
                    unique case (cur.frame)
                        FRAME_ZERO: next_cur.rsp.rdata = frame0_rdata_in;
                        FRAME_ONE:  next_cur.rsp.rdata = frame1_rdata_in;
                        FRAME_TWO:  next_cur.rsp.rdata = {16'h0000, frame2_rdata_in};
                        FRAME_NONE: next_cur.rsp.rdata = 32'h0000_0000;
                    endcase
                end
            end
        endcase
    end

    // state register
    // writes stay locked after reset until the first unlock pulse;
    // the reset branch loads constants only
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur          <= '0;
            cur.state    <= ST_IDLE;
            cur.unlocked <= `UNLOCK_RESET;
        end else begin
            // every field follows its next value
            cur <= next_cur;
        end
    end

    // outputs straight from flip-flops
    // no logic sits between the state register and the ports, so
    // the peripheral buses see clean, glitch-free request words
    assign cpu_rsp_out    = cur.rsp;
    assign frame0_req_out = cur.f0;
    assign frame1_req_out = cur.f1;
    assign frame2_req_out = cur.f2;
    assign region_sel_out = cur.sel;
    assign unlocked_out   = cur.unlocked;

endmodule
`default_nettype wire

// [verif/frame_decoder_props.sv]
// Purpose: port assertions for the peripheral frame decoder
// Assumes: one clock, async active-low reset
// Notes:   bound to the decoder below the module
`timescale 1ns/100ps
`include "frame_decoder_cfg.svh"
`default_nettype none
module frame_decoder_props
    import frame_decoder_pkg::*;
(
    input wire logic     sys_clk_in,
    input wire logic     reset_n_in,
    input wire cpu_req_t cpu_req_in,
    input wire logic     unlock_exec_in,
    input wire logic     lock_exec_in,
    input wire logic     code_sec_grant_in,
    input wire cpu_rsp_t cpu_rsp_out,
    input wire per_req_t frame0_req_out,
    input wire per_req_t frame1_req_out,
    input wire per_req_t frame2_req_out,
    input wire logic [22:0] region_sel_out,
    input wire logic     unlocked_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic took;  // a request was taken last cycle
    logic take;  // a request is taken this cycle
    logic bus_v; // any peripheral bus request
    assign take  = cpu_req_in.valid && !took;
    assign bus_v = frame0_req_out.valid || frame1_req_out.valid || frame2_req_out.valid;
    // remembers the busy cycle after each taken request
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            took <= 1'b0;
        end else begin
            took <= take;
        end
    end
    a_sel_one_hot: assert property ($onehot0(region_sel_out))
        else $error("more than one region select");
    a_sel_one_bus: assert property (|region_sel_out |-> $onehot({frame0_req_out.valid,
        frame1_req_out.valid, frame2_req_out.valid})) else $error("select without one bus");
    a_bus_then_done: assert property (bus_v |=> cpu_rsp_out.done
        && cpu_rsp_out.result == RESULT_ACCEPTED) else $error("bus request not answered");
    a_answer_two_cycles: assert property (take |=> !cpu_rsp_out.done ##1 cpu_rsp_out.done)
        else $error("answer not two cycles after request");
    a_frame_two_narrow: assert property (frame2_req_out.valid |-> !frame2_req_out.wide
        && frame2_req_out.wdata[31:16] == 16'h0000) else $error("wide access on narrow bus");
    a_lock_closes: assert property (lock_exec_in |=> !unlocked_out)
        else $error("lock left writes open");
    a_unlock_opens: assert property (unlock_exec_in && !lock_exec_in |=> unlocked_out)
        else $error("unlock did not open writes");
    a_refused_zero: assert property (cpu_rsp_out.done && cpu_rsp_out.result != RESULT_ACCEPTED
        |-> cpu_rsp_out.rdata == 32'h0000_0000) else $error("refused access returned data");
    a_flash_guard: assert property (take && !code_sec_grant_in && cpu_req_in.addr inside
        {[`FLASH_LO:`FLASH_HI]} |=> !frame0_req_out.valid ##1 cpu_rsp_out.result == RESULT_PROTECTED)
        else $error("flash reached without grant");
    a_mailbox_open: assert property (take && cpu_req_in.write && cpu_req_in.wide && cpu_req_in.addr
        inside {[`CANMBX_LO:`CANMBX_HI]} |=> frame1_req_out.valid) else $error("mailbox write blocked");
    c_write: cover property (take && cpu_req_in.write);
    c_protected: cover property (cpu_rsp_out.done && cpu_rsp_out.result == RESULT_PROTECTED);
    c_narrow_bus: cover property (frame2_req_out.valid);
endmodule
bind peripheral_frame_decoder frame_decoder_props props_u (.sys_clk_in, .reset_n_in, .cpu_req_in,
    .unlock_exec_in, .lock_exec_in, .code_sec_grant_in, .cpu_rsp_out, .frame0_req_out,
    .frame1_req_out, .frame2_req_out, .region_sel_out, .unlocked_out);
`default_nettype wire

// [verif/frame_peripheral_model.sv]
// Purpose: peripheral register blocks answering the three frame buses
// Assumes: read data is wanted while the bus request is valid
// Notes:   idle buses show the inverse of their last word
`timescale 1ns/100ps
`default_nettype none
module frame_peripheral_model
    import frame_decoder_pkg::*;
(
    input  wire logic     sys_clk_in,
    input  wire per_req_t bus0_in,
    input  wire per_req_t bus1_in,
    input  wire per_req_t bus2_in,
    output logic [31:0]   rdata0_out,
    output logic [31:0]   rdata1_out,
    output logic [15:0]   rdata2_out
);
    logic [21:0] last0 = '0; // last address on each bus
    logic [21:0] last1 = '0;
    logic [21:0] last2 = '0;
    // word pattern derived from the address
    function automatic logic [31:0] pat(input logic [21:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    // remember the last address of each bus
    always_ff @(posedge sys_clk_in) begin
        if (bus0_in.valid) last0 <= bus0_in.addr;
        if (bus1_in.valid) last1 <= bus1_in.addr;
        if (bus2_in.valid) last2 <= bus2_in.addr;
    end
    // direct and wide buses answer whole words
    assign rdata0_out = bus0_in.valid ? pat(bus0_in.addr) : ~pat(last0);
    assign rdata1_out = bus1_in.valid ? pat(bus1_in.addr) : ~pat(last1);
    assign rdata2_out = bus2_in.valid ? bus2_in.addr[15:0] ^ 16'h3c3c : ~(last2[15:0] ^ 16'h3c3c);
endmodule
`default_nettype wire

// [verif/test_peripheral_frame_decoder.sv]
// Purpose: self-checking bench for the peripheral frame decoder
// Assumes: inputs change on the falling edge
// Notes:   one access every few cycles
`timescale 1ns/100ps
`include "frame_decoder_cfg.svh"
`default_nettype none
module test_peripheral_frame_decoder;
    import frame_decoder_pkg::*;
    logic sys_clk_in;
    logic reset_n_in;
    cpu_req_t cpu_req;
    logic unl_exec, lck_exec, grant;
    logic [22:0] mask, sel;
    logic [31:0] rd0, rd1;
    logic [15:0] rd2;
    cpu_rsp_t rsp;
    per_req_t pr [3];
    logic unlocked;
    int fails = 0;
    int num_checks = 0;
    logic [21:0] lo [20] = '{`EMU_LO, `FLASH_LO, `CODESEC_LO, `EXTBUS_LO, `TIMER_LO, `INTEXP_LO,
        `VECTOR_LO, `CANCTL_LO, `CANMBX_LO, `SYSCTL_LO, `SPIA_LO, `SCIA_LO, `EXTINT_LO, `PINMUX_LO,
        `PINDAT_LO, `CONV_LO, `EVA_LO, `EVB_LO, `SCIB_LO, `SERPORT_LO};
    logic [21:0] rsv [8] = '{22'h00_0A00, 22'h00_0AF0, 22'h00_0B40, 22'h00_0E00, 22'h00_6200,
        22'h00_7000, 22'h00_7030, 22'h00_7840};
    int pbit [6] = '{22, 21, 20, 16, 13, 9};
    peripheral_frame_decoder dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .cpu_req_in(cpu_req), .unlock_exec_in(unl_exec), .lock_exec_in(lck_exec),
        .code_sec_grant_in(grant), .can_prot_mask_in(mask), .frame0_rdata_in(rd0),
        .frame1_rdata_in(rd1), .frame2_rdata_in(rd2), .cpu_rsp_out(rsp), .frame0_req_out(pr[0]),
        .frame1_req_out(pr[1]), .frame2_req_out(pr[2]), .region_sel_out(sel), .unlocked_out(unlocked));
    frame_peripheral_model model_u (.sys_clk_in(sys_clk_in), .bus0_in(pr[0]), .bus1_in(pr[1]),
        .bus2_in(pr[2]), .rdata0_out(rd0), .rdata1_out(rd1), .rdata2_out(rd2));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one cpu access; bit_no below zero means no select expected
    task automatic acc(input logic w, input logic wd, input logic [21:0] a, input result_t er,
                       input int bit_no);
        int fr;
        int k;
        logic [31:0] wdat;
        fr = (a >= 22'h00_7000) ? 2 : (a >= 22'h00_6000) ? 1 : 0;
        wdat = {~a[9:0], a};
        @(negedge sys_clk_in);
        cpu_req <= '{1'b1, w, wd, a, wdat};
        @(negedge sys_clk_in);
        cpu_req.valid <= 1'b0;
        check("select", {9'h0, sel}, bit_no < 0 ? 32'h0 : 32'h1 << bit_no);
        if (bit_no >= 0) check("bus addr", {10'h0, pr[fr].addr}, {10'h0, a});
        if (bit_no >= 0 && w && fr > 0) check("bus wdata", pr[fr].wdata, fr == 2 ? {16'h0, wdat[15:0]} : wdat);
        k = 0;
        do begin
            @(negedge sys_clk_in);
            k++;
        end while (!rsp.done && k < 3);
        if (!rsp.done) begin
            fails++;
            results();
        end
        check("result", {30'h0, rsp.result}, {30'h0, er});
        if (!w && er == RESULT_ACCEPTED) check("rdata", rsp.rdata, fr == 2 ?
            {16'h0, a[15:0] ^ 16'h3c3c} : {a[15:0], ~a[15:0]});
        if (er != RESULT_ACCEPTED) check("refused rdata", rsp.rdata, 32'h0);
    endtask
    task automatic pulse(input logic u, input logic l);
        @(negedge sys_clk_in);
        unl_exec <= u;
        lck_exec <= l;
        @(negedge sys_clk_in);
        unl_exec <= 1'b0;
        lck_exec <= 1'b0;
        check("unlocked", {31'h0, unlocked}, {31'h0, u & !l});
    endtask
    task automatic t_map();
        for (int i = 0; i < 20; i++) acc(1'b0, lo[i] < 22'h00_7000, lo[i], RESULT_ACCEPTED, 22 - i);
        acc(1'b0, 1'b0, `CODESEC_HI, RESULT_ACCEPTED, 20);
        $display("map test done");
    endtask
    task automatic t_reserved();
        for (int i = 0; i < 8; i++) acc(i[0], 1'b0, rsv[i], RESULT_RESERVED, -1);
        $display("reserved test done");
    endtask
    task automatic t_width();
        acc(1'b0, 1'b1, `PINDAT_LO, RESULT_WIDTH, -1);
        acc(1'b1, 1'b1, `SPIA_LO, RESULT_WIDTH, -1);
        acc(1'b0, 1'b0, `CANCTL_LO, RESULT_WIDTH, -1);
        acc(1'b0, 1'b1, `CANCTL_LO + 22'h1, RESULT_WIDTH, -1);
        acc(1'b1, 1'b0, `TIMER_LO, RESULT_ACCEPTED, 18);
        acc(1'b1, 1'b1, `EXTBUS_LO, RESULT_ACCEPTED, 19);
        $display("width test done");
    endtask
    task automatic t_protect();
        for (int i = 0; i < 6; i++) acc(1'b1, 1'b0, lo[22 - pbit[i]], RESULT_PROTECTED, -1);
        mask = 23'h1;
        acc(1'b1, 1'b1, `CANCTL_LO, RESULT_PROTECTED, -1);
        acc(1'b1, 1'b1, `CANMBX_LO, RESULT_ACCEPTED, 14);
        pulse(1'b1, 1'b0);
        for (int i = 0; i < 6; i++) acc(1'b1, 1'b0, lo[22 - pbit[i]], RESULT_ACCEPTED, pbit[i]);
        acc(1'b1, 1'b1, `CANCTL_LO, RESULT_ACCEPTED, 15);
        pulse(1'b0, 1'b1);
        acc(1'b1, 1'b0, `SYSCTL_LO, RESULT_PROTECTED, -1);
        pulse(1'b1, 1'b1);
        acc(1'b1, 1'b0, `PINMUX_LO, RESULT_PROTECTED, -1);
        mask = 23'h0;
        acc(1'b1, 1'b1, `CANCTL_LO, RESULT_ACCEPTED, 15);
        $display("protect test done");
    endtask
    task automatic t_flash();
        pulse(1'b1, 1'b0);
        grant = 1'b0;
        acc(1'b0, 1'b1, `FLASH_LO, RESULT_PROTECTED, -1);
        acc(1'b1, 1'b0, `FLASH_HI, RESULT_PROTECTED, -1);
        grant = 1'b1;
        acc(1'b0, 1'b1, `FLASH_HI - 22'h1, RESULT_ACCEPTED, 21);
        $display("flash test done");
    endtask
    task automatic t_busy();
        int n;
        n = 0;
        @(negedge sys_clk_in);
        cpu_req <= '{1'b1, 1'b0, 1'b1, `TIMER_LO, 32'h0};
        @(negedge sys_clk_in);
        cpu_req <= '{1'b1, 1'b0, 1'b1, `EXTBUS_LO, 32'h0};
        @(negedge sys_clk_in);
        cpu_req.valid <= 1'b0;
        // the answer to the first request already stands here
        n += rsp.done;
        repeat (4) begin
            @(negedge sys_clk_in);
            n += rsp.done;
        end
        check("answers", n, 1);
        $display("busy test done");
    endtask
    // free-running system clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // main sequence
    initial begin
        reset_n_in = 1'b0;
        cpu_req = '0;
        unl_exec = 1'b0;
        lck_exec = 1'b0;
        grant = 1'b1;
        mask = 23'h0;
        repeat (3) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        check("reset unlocked", {31'h0, unlocked}, 32'h0);
        t_map();
        t_reserved();
        t_width();
        t_protect();
        t_flash();
        t_busy();
        results();
    end
endmodule
`default_nettype wire
